// [amot_regs.v]
// Alert mask two, low-bit readback, config three and overheat timer registers on AHB-Lite
`timescale 1ns/1ps
`include "amot_map.vh"

module amot_regs #(
    parameter STEP_CYC = `AMOT_STEP_CYC,
    parameter SLOW_CYC = `AMOT_SLOW_CYC,
    parameter FAST_CYC = `AMOT_FAST_CYC
) (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Measurement results, ten bits each
    input  wire [9:0]  meas_v25,
    input  wire [9:0]  meas_core,
    input  wire [9:0]  meas_v33,
    input  wire [9:0]  meas_v5,
    input  wire [9:0]  meas_v12,
    input  wire [9:0]  meas_rem1,
    input  wire [9:0]  meas_local,
    input  wire [9:0]  meas_rem2,
    input  wire        msb_read,
    output reg  [63:0] msb_frozen,
    // Status conditions and pin selection
    input  wire        high_rail_fault,
    input  wire        sixth_id_input,
    input  wire [2:0]  fan_fault,
    input  wire        fan_four_fault,
    input  wire        gpio_in_asserted,
    input  wire [1:0]  diode_fault,
    input  wire [1:0]  shared_pin_function,
    input  wire        overheat_pin_in,
    input  wire        shared_overheat_in,
    // Control outputs
    output reg         alert_n,
    output reg         alert_select,
    output reg         overheat_enable,
    output reg         fan_boost,
    output reg         tach_tick,
    output reg  [3:0]  steady_drive,
    output reg         shared_pin_flag
);
    reg  [7:0]  mask_r;
    reg  [7:0]  cfg_r;
    reg  [7:0]  tstat_r;
    reg  [7:0]  tlim_r;
    reg  [7:0]  ctrl_r;
    reg  [63:0] held_r;
    reg         freeze_r;
    reg  [31:0] step_cnt_r;
    reg  [8:0]  dur_r;
    reg  [31:0] tach_cnt_r;
    reg         ap_wr_r;
    reg         ap_rd_r;
    reg  [7:0]  ap_addr_r;
    reg         oh_q_r;
    reg         id_q_r;
    wire        ap_go;
    wire        oh_active;
    wire        oh_rise;
    wire        id_change;
    wire        rd_tstat;
    wire        oh_sel;
    wire [7:0]  cond;
    wire [7:0]  low_v;
    wire [7:0]  low_m;
    wire [7:0]  ap_idx;
    reg  [7:0]  rd_mux;

    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign ap_go = hsel & hready & htrans[1];
    // Unmapped upper address bits alias nothing
    assign ap_idx = (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'hFF;
    assign oh_sel = (shared_pin_function == `AMOT_PF_OVERHEAT);
    // Shared pin contributes only when its function is overheat
    assign oh_active = cfg_r[`AMOT_BIT_OHEN] &
                       (overheat_pin_in | (oh_sel & shared_overheat_in));
    assign oh_rise   = oh_active & ~oh_q_r;
    assign id_change = sixth_id_input ^ id_q_r;
    assign rd_tstat  = ap_rd_r & hit(ap_addr_r, `AMOT_OFS_TSTAT);

    // Live results pass through unless a low-bits read froze them
    wire [63:0] live = {meas_rem2[9:2], meas_local[9:2], meas_rem1[9:2], meas_v12[9:2],
                        meas_v5[9:2], meas_v33[9:2], meas_core[9:2], meas_v25[9:2]};
    wire [15:0] live_lo = {meas_rem2[1:0], meas_local[1:0], meas_rem1[1:0], meas_v12[1:0],
                           meas_v5[1:0], meas_v33[1:0], meas_core[1:0], meas_v25[1:0]};
    reg  [15:0] held_lo_r;
    assign low_v = held_lo_r[7:0];
    assign low_m = held_lo_r[15:8];

    assign cond[0] = ctrl_r[`AMOT_BIT_IDMODE] ? id_change : high_rail_fault;
    assign cond[1] = oh_active;
    assign cond[4:2] = fan_fault;
    assign cond[5] = (shared_pin_function == `AMOT_PF_TACH) ? fan_four_fault :
                     oh_sel ? shared_pin_flag :
                     (shared_pin_function == `AMOT_PF_GPIO) ? gpio_in_asserted :
                     1'b0;
    assign cond[7:6] = diode_fault;

    // Decoded in the address phase so the word stands for the whole data phase
    always @* begin
        rd_mux = 8'h00;
        case (ap_idx)
            `AMOT_OFS_MASK2: rd_mux = mask_r;
            `AMOT_OFS_LOWV:  rd_mux = low_v;
            `AMOT_OFS_LOWM:  rd_mux = low_m;
            `AMOT_OFS_CFG3:  rd_mux = cfg_r;
            `AMOT_OFS_TSTAT: rd_mux = tstat_r;
            `AMOT_OFS_TLIM:  rd_mux = tlim_r;
            `AMOT_OFS_CTRL:  rd_mux = ctrl_r;
            `AMOT_OFS_FLAGS: rd_mux = {7'h00, freeze_r};
            default:         rd_mux = 8'h00;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r   <= 1'b0;
            ap_rd_r   <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            mask_r    <= `AMOT_RST_MASK2;
            cfg_r     <= `AMOT_RST_CFG3;
            tlim_r    <= `AMOT_RST_TLIM;
            ctrl_r    <= `AMOT_RST_CTRL;
        end else begin
            ap_wr_r   <= ap_go & hwrite;
            ap_rd_r   <= ap_go & ~hwrite;
            ap_addr_r <= ap_idx;
            hrdata    <= 32'h0000_0000;
            if (ap_go & ~hwrite) begin
                hrdata <= {24'h000000, rd_mux};
            end
            if (ap_wr_r) begin
                if (hit(ap_addr_r, `AMOT_OFS_MASK2)) begin
                    mask_r <= {hwdata[7:2], 1'b0, hwdata[0]};
                end
                if (hit(ap_addr_r, `AMOT_OFS_CFG3) && !ctrl_r[`AMOT_BIT_LOCK]) begin
                    cfg_r <= hwdata[7:0];
                end
                if (hit(ap_addr_r, `AMOT_OFS_TLIM)) begin
                    tlim_r <= hwdata[7:0];
                end
                // Lock is sticky until reset, as software cannot be trusted to undo it
                if (hit(ap_addr_r, `AMOT_OFS_CTRL)) begin
                    ctrl_r <= {6'h00, hwdata[1], hwdata[0] | ctrl_r[0]};
                end
            end
        end
    end

    // Freeze takes effect at the end of the read, after the word was loaded
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freeze_r   <= 1'b0;
            held_r     <= 64'h0;
            held_lo_r  <= 16'h0000;
            msb_frozen <= 64'h0;
        end else begin
            if (ap_rd_r && (hit(ap_addr_r, `AMOT_OFS_LOWV) || hit(ap_addr_r, `AMOT_OFS_LOWM))) begin
                freeze_r <= 1'b1;
            end else if (msb_read) begin
                freeze_r <= 1'b0;
            end
            if (!freeze_r) begin
                held_r    <= live;
                held_lo_r <= live_lo;
            end
            msb_frozen <= held_r;
        end
    end

    // Duration counter: bit 0 alone until two steps pass, then the full count
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oh_q_r          <= 1'b0;
            id_q_r          <= 1'b0;
            step_cnt_r      <= 32'h0000_0000;
            dur_r           <= 9'h000;
            tstat_r         <= `AMOT_RST_TSTAT;
            shared_pin_flag <= 1'b0;
        end else begin
            oh_q_r <= oh_active;
            id_q_r <= sixth_id_input;
            if (!oh_active) begin
                step_cnt_r <= 32'h0000_0000;
                dur_r      <= 9'h000;
            end else if (step_cnt_r == STEP_CYC - 1) begin
                step_cnt_r <= 32'h0000_0000;
                if (dur_r != 9'h0FF) begin
                    dur_r <= dur_r + 9'h001;
                end
            end else begin
                step_cnt_r <= step_cnt_r + 32'h0000_0001;
            end
            if (oh_active && dur_r >= 9'h002) begin
                tstat_r <= dur_r[7:0];
            end else if (oh_rise) begin
                tstat_r <= 8'h01;
            end else if (rd_tstat) begin
                tstat_r <= 8'h00;
            end
            if (oh_sel && oh_active && (tlim_r == 8'h00 || dur_r > {1'b0, tlim_r})) begin
                shared_pin_flag <= 1'b1;
            end else if (!oh_active) begin
                shared_pin_flag <= 1'b0;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tach_cnt_r      <= 32'h0000_0000;
            tach_tick       <= 1'b0;
            alert_n         <= 1'b1;
            alert_select    <= 1'b0;
            overheat_enable <= 1'b0;
            fan_boost       <= 1'b0;
            steady_drive    <= 4'h0;
        end else begin
            tach_tick <= 1'b0;
            if (tach_cnt_r >= (cfg_r[`AMOT_BIT_FAST] ? FAST_CYC : SLOW_CYC) - 1) begin
                tach_cnt_r <= 32'h0000_0000;
                tach_tick  <= 1'b1;
            end else begin
                tach_cnt_r <= tach_cnt_r + 32'h0000_0001;
            end
            alert_n         <= ~(cfg_r[`AMOT_BIT_ALERTSEL] & |(cond & ~mask_r));
            alert_select    <= cfg_r[`AMOT_BIT_ALERTSEL];
            overheat_enable <= cfg_r[`AMOT_BIT_OHEN];
            fan_boost       <= cfg_r[`AMOT_BIT_BOOST] & oh_active;
            steady_drive    <= cfg_r[`AMOT_BIT_DC4:`AMOT_BIT_DC1];
        end
    end
endmodule

// [amot_map.vh]
// Register offsets, field positions, reset values and timing counts for the alert mask and timer slice
`ifndef AMOT_MAP_VH
`define AMOT_MAP_VH
`define AMOT_OFS_MASK2      8'h75
`define AMOT_OFS_LOWV       8'h76
`define AMOT_OFS_LOWM       8'h77
`define AMOT_OFS_CFG3       8'h78
`define AMOT_OFS_TSTAT      8'h79
`define AMOT_OFS_TLIM       8'h7A
`define AMOT_OFS_CTRL       8'h7E
`define AMOT_OFS_FLAGS      8'h7F
`define AMOT_RST_MASK2      8'h00
`define AMOT_RST_CFG3       8'h00
`define AMOT_RST_TSTAT      8'h00
`define AMOT_RST_TLIM       8'h00
`define AMOT_RST_CTRL       8'h00
`define AMOT_BIT_HIGHRAIL   0
`define AMOT_BIT_OVT        1
`define AMOT_BIT_FAN_ONE_FAULT_MASK       2
`define AMOT_BIT_FAN_THREE_FAULT_MASK       4
`define AMOT_BIT_SHARED     5
`define AMOT_BIT_D1         6
`define AMOT_BIT_D2         7
`define AMOT_BIT_ALERTSEL   0
`define AMOT_BIT_OHEN       1
`define AMOT_BIT_BOOST      2
`define AMOT_BIT_FAST       3
`define AMOT_BIT_DC1        4
`define AMOT_BIT_DC4        7
`define AMOT_BIT_LOCK       0
`define AMOT_BIT_IDMODE     1
`define AMOT_PF_TACH        2'h0
`define AMOT_PF_OVERHEAT    2'h1
`define AMOT_PF_GPIO        2'h2
`define AMOT_STEP_US        22760
`define AMOT_CLK_MHZ        100
`define AMOT_STEP_CYC       (`AMOT_STEP_US * `AMOT_CLK_MHZ)
`define AMOT_SLOW_US        1000000
`define AMOT_FAST_US        250000
`define AMOT_SLOW_CYC       (`AMOT_SLOW_US * `AMOT_CLK_MHZ)
`define AMOT_FAST_CYC       (`AMOT_FAST_US * `AMOT_CLK_MHZ)
`endif

// [amot_host_mdl.sv]
// Host-side model that reads the MSB result registers
`timescale 1ns/1ps
module amot_host_mdl (
    // Clock and reset
    input  logic hclk,
    input  logic hresetn,
    // Read request from the bench, read strobe to the block
    input  logic rd_go,
    output logic msb_read
);
    // Strobe alternates while the request is held, so a held request reads every other cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) msb_read <= 1'b0;
        else msb_read <= rd_go & !msb_read;
    end
endmodule

// [amot_regs_chk.sv]
// Assertions on the alert mask and overheat timer slice ports
`timescale 1ns/1ps
module amot_regs_chk (
    // Clock and reset
    input logic        hclk,
    input logic        hresetn,
    // Bus
    input logic        hsel,
    input logic        hready,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hrdata,
    // Status in, control out
    input logic        high_rail_fault,
    input logic        sixth_id_input,
    input logic [2:0]  fan_fault,
    input logic        fan_four_fault,
    input logic        gpio_in_asserted,
    input logic [1:0]  diode_fault,
    input logic        overheat_pin_in,
    input logic        shared_overheat_in,
    input logic        alert_n,
    input logic        alert_select,
    input logic        fan_boost,
    input logic        tach_tick,
    input logic        shared_pin_flag
);
    logic id_q;
    always @(posedge hclk) id_q <= sixth_id_input;
    wire rd_tk = hsel & hready & htrans[1] & !hwrite;
    wire hot = overheat_pin_in | shared_overheat_in;
    // Overheat counts too, its mask bit is fixed at zero
    wire quiet = !(high_rail_fault | (|fan_fault) | fan_four_fault | gpio_in_asserted
        | (|diode_fault) | hot | shared_pin_flag | (sixth_id_input ^ id_q));
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_quiet; quiet [*4]; endsequence
    sequence s_cool; !hot [*3]; endsequence
    read_slot_a: assert property (!$past(rd_tk) |-> hrdata == 32'h0)
        else $error("read data out of slot");
    byte_wide_a: assert property (hrdata[31:8] == 24'h0)
        else $error("read data above bit 7");
    alert_gate_a: assert property (!alert_select [*2] |-> alert_n)
        else $error("alert while pin drives fan");
    alert_quiet_a: assert property (s_quiet |-> alert_n)
        else $error("alert with no condition");
    alert_cause_a: assert property ($fell(alert_n) |-> alert_select && !$past(quiet))
        else $error("alert without cause");
    tick_gap_a: assert property (tach_tick |=> !tach_tick [*8])
        else $error("tach ticks too close");
    boost_cause_a: assert property ($rose(fan_boost) |-> $past(hot))
        else $error("boost without overheat");
    flag_drop_a: assert property (s_cool |-> !shared_pin_flag)
        else $error("flag kept after overheat");
endmodule

bind amot_regs amot_regs_chk u_chk (.*);

// [amot_regs_tb.sv]
// Self-checking bench for the alert mask and overheat timer slice
`timescale 1ns/1ps
module amot_regs_tb;
    localparam MSK = 8'h75, LOV = 8'h76, LOM = 8'h77, CFG = 8'h78, TST = 8'h79;
    localparam LIM = 8'h7A, CTL = 8'h7E;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_go = 1'b0;
    logic        overheat_pin_in = 1'b0, hreadyout, hresp, msb_read, alert_n;
    logic        alert_select, overheat_enable, fan_boost, tach_tick, shared_pin_flag;
    logic [1:0]  htrans = 2'h0, shared_pin_function = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [63:0] msb_frozen;
    logic [79:0] meas = 80'h0;
    logic [7:0]  cond = 8'h0;
    logic [3:0]  steady_drive;
    logic        sixth_id_input = 1'b0, gpio_in_asserted = 1'b0, shared_overheat_in = 1'b0;
    int          n_mismatch = 0, n_checks = 0, k;

    initial begin
        forever #5 hclk = ~hclk;
    end

    amot_regs #(.STEP_CYC(10), .SLOW_CYC(40), .FAST_CYC(10)) DUT (
        .*, .hsel(1'b1), .hsize(3'h2), .hready(hreadyout), .high_rail_fault(cond[0]),
        .fan_fault(cond[4:2]), .fan_four_fault(cond[5]), .diode_fault(cond[7:6]),
        .meas_v25(meas[9:0]), .meas_core(meas[19:10]), .meas_v33(meas[29:20]),
        .meas_v5(meas[39:30]), .meas_v12(meas[49:40]), .meas_rem1(meas[59:50]),
        .meas_local(meas[69:60]), .meas_rem2(meas[79:70])
    );
    amot_host_mdl HOST (.*);

    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task chk(input logic [31:0] exp, got, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Read data is taken at the data phase edge; an idle cycle follows each read
    task bus(input logic w, input logic [7:0] idx, d, input string what = "");
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        if (!w) begin
            chk({24'h0, d}, hrdata, what);
            @(posedge hclk);
        end
    endtask

    task set_meas(input logic [7:0] msb, input logic [15:0] lsb);
        for (int i = 0; i < 8; i++) meas[i*10 +: 10] <= {msb, lsb[i*2 +: 2]};
    endtask

    task ticks(input int exp);
        int t;
        t = 0;
        repeat (80) begin
            @(posedge hclk);
            #1 if (tach_tick === 1'b1) t++;
        end
        chk(exp, t, "tick count");
        @(posedge hclk);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        cyc(8);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, MSK, 8'h00, "mask rst");
        bus(0, CFG, 8'h00, "cfg rst");
        bus(0, TST, 8'h00, "timer rst");
        bus(0, 8'h70, 8'h00, "unmapped");
        bus(1, MSK, 8'hFF);
        bus(0, MSK, 8'hFD, "mask fixed bit");
        set_meas(8'h5A, 16'hC639);
        cyc(3);
        bus(0, LOV, 8'h39, "low volt");
        bus(0, LOM, 8'hC6, "low misc");
        set_meas(8'hA5, 16'h0000);
        cyc(3);
        bus(0, LOV, 8'h39, "frozen low");
        #1 chk(32'h5A, {24'h0, msb_frozen[63:56]}, "frozen msb");
        @(posedge hclk);
        rd_go <= 1'b1;
        cyc(1);
        rd_go <= 1'b0;
        cyc(4);
        #1 chk(32'hA5, {24'h0, msb_frozen[63:56]}, "thawed msb");
        @(posedge hclk);
        bus(0, LOM, 8'h00, "thawed low");
        bus(1, CFG, 8'h01);
        for (k = 0; k < 8; k++) begin
            if (k != 1) begin
                cond <= 8'h01 << k;
                bus(1, MSK, 8'h00);
                cyc(3);
                #1 chk(32'h0, {31'h0, alert_n}, "alert open");
                @(posedge hclk);
                bus(1, MSK, 8'h01 << k);
                cyc(3);
                #1 chk(32'h1, {31'h0, alert_n}, "alert masked");
                @(posedge hclk);
            end
        end
        bus(1, CFG, 8'h00);
        cond <= 8'h04;
        cyc(3);
        #1 chk(32'h1, {31'h0, alert_n}, "fan drive pin");
        @(posedge hclk);
        cond <= 8'h00;
        bus(1, CFG, 8'hF3);
        cyc(50);
        #1 chk(32'h1F, {27'h0, steady_drive, overheat_enable}, "cfg outs");
        ticks(2);
        bus(1, CFG, 8'hFF);
        bus(1, CTL, 8'h01);
        bus(1, CFG, 8'h00);
        bus(0, CFG, 8'hFF, "locked cfg");
        cyc(50);
        ticks(8);
        shared_pin_function <= 2'h1;
        bus(1, LIM, 8'h03);
        overheat_pin_in <= 1'b1;
        cyc(3);
        #1 chk(32'h1, {31'h0, fan_boost}, "boost");
        @(posedge hclk);
        overheat_pin_in <= 1'b0;
        cyc(3);
        bus(0, TST, 8'h01, "asserted");
        bus(0, TST, 8'h00, "read clear");
        overheat_pin_in <= 1'b1;
        cyc(20);
        #1 chk(32'h0, {31'h0, shared_pin_flag}, "below limit");
        cyc(35);
        #1 chk(32'h1, {31'h0, shared_pin_flag}, "over limit");
        @(posedge hclk);
        overheat_pin_in <= 1'b0;
        cyc(3);
        bus(0, TST, 8'h05, "duration");
        shared_pin_function <= 2'h2;
        gpio_in_asserted <= 1'b1;
        bus(1, MSK, 8'h00);
        cyc(3);
        #1 chk(32'h0, {31'h0, alert_n}, "gpio open");
        @(posedge hclk);
        bus(1, MSK, 8'h20);
        cyc(3);
        #1 chk(32'h1, {31'h0, alert_n}, "gpio masked");
        @(posedge hclk);
        gpio_in_asserted <= 1'b0;
        shared_pin_function <= 2'h1;
        shared_overheat_in <= 1'b1;
        cyc(3);
        #1 chk(32'h1, {31'h0, fan_boost}, "shared pin boost");
        @(posedge hclk);
        shared_overheat_in <= 1'b0;
        report_and_stop;
    end

    // Whole run is about 510 cycles
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop;
    end
endmodule
